/* rtl/adss_map.vh */
// Constants for the ADC sample sequencer block
`ifndef ADSS_MAP_VH
`define ADSS_MAP_VH
`define ADSS_CLK_HZ      50000000
`define ADSS_ADC_HZ      16667000
`define ADSS_CLK_DIV     ((`ADSS_CLK_HZ + `ADSS_ADC_HZ / 2) / `ADSS_ADC_HZ)
`define ADSS_NSEQ        4
`define ADSS_RES_W       10
`define ADSS_WORD_W      32
`define ADSS_NIB_W       68
`define ADSS_DEP0        4'h8
`define ADSS_DEP1        4'h4
`define ADSS_DEP2        4'h4
`define ADSS_DEP3        4'h1
`define ADSS_OFF0        7'h00
`define ADSS_OFF1        7'h20
`define ADSS_OFF2        7'h30
`define ADSS_OFF3        7'h40
`define ADSS_CTL_DIFF    0
`define ADSS_CTL_END     1
`define ADSS_CTL_IE      2
`define ADSS_CTL_TEMP    3
`define ADSS_TRIG_PROC   4'h0
`define ADSS_TRIG_EXT    4'h1
`define ADSS_TRIG_ALWAYS 4'hF
`define ADSS_PRI_RST     8'hE4
`define ADSS_AVG_MAX     3'h6
`endif

/* rtl/adss_top.v */
// ADC sample sequencer control: triggers, steps, averaging, result FIFOs
//
// Behaviour
// - FIFO words are 32 bits, result in low 10 bits.
// - Sequencers 0..3 hold 8,4,4,1 steps; FIFO depths match.
// - Each step uses an input nibble and a control nibble.
// - Sequencer runs only when enabled; configuration accepted anytime.
// - Raw interrupt set after any step with interrupt flag.
// - Sequence ends after first step whose end flag is set.
// - Each pop removes and returns the oldest FIFO entry.
// - Head, tail, full, empty visible; overflow and underflow flagged.
// - ADC rate derived near 16.667 MHz, inside 14-18 MHz.
// - Interrupt output only for masked-in sequencers.
// - Raw status shown, and raw AND mask shown separately.
// - Writing 1 clears a sequencer interrupt; 0 does nothing.
// - Simultaneous triggers served by priority value, 0 first.
// - Per-sequencer trigger select, processor and always at least.
// - Processor trigger bit starts a processor-triggered sequencer.
// - Shared averager of up to 64 samples, off at reset.
// - Single-ended code runs 0x000 to 0x3FF.
// - Differential pair k uses input 2k positive, 2k+1 negative.
// - Differential zero gives 0x1FF, spanning 0 to 0x3FF.
// - Loopback test mode supplies data inside the digital section.
// - Priority resets to 0,1,2,3 for sequencers 0..3.
`timescale 1ns/10ps
`default_nettype none
`include "adss_map.vh"

module adss_top #(
  parameter CLK_DIV = `ADSS_CLK_DIV,
  parameter RES_W   = `ADSS_RES_W
) (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire [3:0]  sequencer_enable_reg,
  input  wire [67:0] step_input_select,
  input  wire [67:0] step_control_nibbles,
  input  wire [15:0] trigger_source_select,
  input  wire [3:0]  ext_trig,
  input  wire [3:0]  software_trigger_bits,
  input  wire        pri_wr,
  input  wire [7:0]  pri_wdata,
  output wire [7:0]  sequencer_priority_reg,
  input  wire [2:0]  averaging_control,
  input  wire        loopback_test_reg,
  input  wire [3:0]  irq_gate_reg,
  input  wire [3:0]  masked_irq_clear_reg,
  output wire [3:0]  raw_irq_flags,
  output wire [3:0]  masked_irq_flags,
  output wire        adc_irq,
  output reg         conv_req,
  output reg  [3:0]  conv_pos,
  output reg  [3:0]  conv_neg,
  output reg         conv_diff,
  output reg         conv_temp,
  input  wire        conv_valid,
  input  wire [9:0]  conv_data,
  input  wire [3:0]  fifo_pop,
  output wire        pop_ready,
  output wire [31:0] result_fifo_port,
  output wire        rd_valid,
  input  wire        rd_ready,
  output wire [11:0] head_ptrs,
  output wire [11:0] tail_ptrs,
  output wire [3:0]  fifo_full,
  output wire [3:0]  fifo_empty,
  output wire [3:0]  fifo_overflow_flags,
  input  wire [3:0]  ovf_clear,
  output wire [3:0]  fifo_underflow_flags,
  input  wire [3:0]  unf_clear,
  output wire        seq_busy
);

  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_REQ  = 4'h2;
  localparam [3:0] S_WAIT = 4'h4;
  localparam [3:0] S_DONE = 4'h8;

  function [3:0] dep;
    input [1:0] s;
    begin
      case (s)
        2'h0:    dep = `ADSS_DEP0;
        2'h1:    dep = `ADSS_DEP1;
        2'h2:    dep = `ADSS_DEP2;
        default: dep = `ADSS_DEP3;
      endcase
    end
  endfunction

  function [6:0] off;
    input [1:0] s;
    begin
      case (s)
        2'h0:    off = `ADSS_OFF0;
        2'h1:    off = `ADSS_OFF1;
        2'h2:    off = `ADSS_OFF2;
        default: off = `ADSS_OFF3;
      endcase
    end
  endfunction

  // ---------------------------------------------
  // ADC rate divider
  // ---------------------------------------------
  reg  [3:0] div_r;
  wire       adc_ce = (div_r == CLK_DIV - 1);

  always @(posedge clk) begin
    if (sys_rst || adc_ce)
      div_r <= 4'h0;
    else
      div_r <= div_r + 4'h1;
  end

  // ---------------------------------------------
  // Priority, triggers and arbitration
  // ---------------------------------------------
  reg  [7:0] pri_r;
  reg  [3:0] pend_r;
  reg  [3:0] st_r;
  reg  [1:0] seq_r;
  reg  [1:0] win;
  reg  [1:0] best;
  reg        win_ok;
  reg  [3:0] trig;
  integer    k;
  integer    j;

  assign sequencer_priority_reg = pri_r;

  always @(posedge clk) begin
    if (sys_rst)
      pri_r <= `ADSS_PRI_RST;
    else if (pri_wr)
      pri_r <= pri_wdata;
  end

  always @* begin
    trig = 4'h0;
    for (k = 0; k < 4; k = k + 1) begin
      case (trigger_source_select[4*k +: 4])
        `ADSS_TRIG_PROC:   trig[k] = software_trigger_bits[k];
        `ADSS_TRIG_EXT:    trig[k] = ext_trig[k];
        `ADSS_TRIG_ALWAYS: trig[k] = 1'b1;
        default:           trig[k] = 1'b0;
      endcase
    end
  end

  // Equal priorities fall back to the lower index
  always @* begin
    win_ok = 1'b0;
    win    = 2'h0;
    best   = 2'h3;
    for (j = 0; j < 4; j = j + 1) begin
      if (pend_r[j] && (!win_ok || pri_r[2*j +: 2] < best)) begin
        win_ok = 1'b1;
        win    = j[1:0];
        best   = pri_r[2*j +: 2];
      end
    end
  end

  wire start = st_r[0] && adc_ce && win_ok;

  always @(posedge clk) begin
    if (sys_rst)
      pend_r <= 4'h0;
    else
      pend_r <= (pend_r | trig) & sequencer_enable_reg
                & ~({3'h0, start} << win);
  end

  // ---------------------------------------------
  // Step sequencer and averager
  // ---------------------------------------------
  reg  [2:0]  step_r;
  reg  [15:0] acc_r;
  reg  [6:0]  acnt_r;
  reg  [4:0]  lbc_r;
  reg  [3:0]  irq_set;
  reg         fw_en;
  reg  [9:0]  fw_data;

  wire [6:0] nidx  = off(seq_r) + {2'h0, step_r, 2'h0};
  wire [3:0] sel_n = step_input_select[nidx +: 4];
  wire [3:0] ctl_n = step_control_nibbles[nidx +: 4];
  wire [2:0] avg_s = (averaging_control > `ADSS_AVG_MAX) ?
                     `ADSS_AVG_MAX : averaging_control;
  wire [6:0] gsz   = 7'h01 << avg_s;
  wire [9:0] lb_d  = {seq_r, step_r, lbc_r};
  wire       got   = loopback_test_reg || conv_valid;
  wire [9:0] smp   = loopback_test_reg ? lb_d : conv_data;
  wire [15:0] sum  = acc_r + {6'h00, smp};
  wire       grp   = (acnt_r + 7'h01 == gsz);
  wire       last  = ctl_n[`ADSS_CTL_END] ||
                     ({1'b0, step_r} == dep(seq_r) - 4'h1);
  wire       run   = sequencer_enable_reg[seq_r];

  assign seq_busy = !st_r[0];

  always @(posedge clk) begin
    if (sys_rst) begin
      st_r     <= S_IDLE;
      seq_r    <= 2'h0;
      step_r   <= 3'h0;
      acc_r    <= 16'h0000;
      acnt_r   <= 7'h00;
      lbc_r    <= 5'h00;
      conv_req <= 1'b0;
      conv_pos <= 4'h0;
      conv_neg <= 4'h0;
      conv_diff <= 1'b0;
      conv_temp <= 1'b0;
    end else begin
      conv_req <= 1'b0;
      case (st_r)
        S_IDLE: begin
          if (start) begin
            seq_r  <= win;
            step_r <= 3'h0;
            acc_r  <= 16'h0000;
            acnt_r <= 7'h00;
            st_r   <= S_REQ;
          end
        end
        S_REQ: begin
          if (adc_ce) begin
            conv_req  <= !loopback_test_reg;
            conv_diff <= ctl_n[`ADSS_CTL_DIFF];
            conv_temp <= ctl_n[`ADSS_CTL_TEMP];
            if (ctl_n[`ADSS_CTL_DIFF]) begin
              conv_pos <= {sel_n[2:0], 1'b0};
              conv_neg <= {sel_n[2:0], 1'b1};
            end else begin
              conv_pos <= sel_n;
              conv_neg <= 4'h0;
            end
            st_r <= S_WAIT;
          end
        end
        S_WAIT: begin
          // Code is taken as delivered: straight or offset binary
          if (got) begin
            lbc_r <= lbc_r + 5'h01;
            if (!run) begin
              st_r <= S_IDLE;
            end else if (grp) begin
              acc_r  <= 16'h0000;
              acnt_r <= 7'h00;
              st_r   <= S_DONE;
            end else begin
              acc_r  <= sum;
              acnt_r <= acnt_r + 7'h01;
              st_r   <= S_REQ;
            end
          end
        end
        S_DONE: begin
          if (last) begin
            st_r <= S_IDLE;
          end else begin
            step_r <= step_r + 3'h1;
            st_r   <= S_REQ;
          end
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // One word per completed group, written in step order
  always @(posedge clk) begin
    if (sys_rst) begin
      fw_en   <= 1'b0;
      fw_data <= 10'h000;
      irq_set <= 4'h0;
    end else begin
      fw_en   <= st_r[2] && got && run && grp;
      fw_data <= sum[avg_s +: 10];
      irq_set <= (st_r[2] && got && run && grp && ctl_n[`ADSS_CTL_IE]) ?
                 (4'h1 << seq_r) : 4'h0;
    end
  end

  // ---------------------------------------------
  // Interrupt status
  // ---------------------------------------------
  reg [3:0] raw_r;

  always @(posedge clk) begin
    if (sys_rst)
      raw_r <= 4'h0;
    else
      raw_r <= (raw_r & ~masked_irq_clear_reg) | irq_set;
  end

  assign raw_irq_flags    = raw_r;
  assign masked_irq_flags = raw_r & irq_gate_reg;
  assign adc_irq          = |masked_irq_flags;

  // ---------------------------------------------
  // Result FIFOs
  // ---------------------------------------------
  reg  [1:0] psel;
  reg  [1:0] fw_seq_r;
  integer    m;
  wire [39:0] hd;
  wire [3:0]  emp;

  always @* begin
    psel = 2'h0;
    for (m = 3; m >= 0; m = m - 1)
      if (fifo_pop[m])
        psel = m[1:0];
  end

  always @(posedge clk) begin
    if (sys_rst)
      fw_seq_r <= 2'h0;
    else
      fw_seq_r <= seq_r;
  end

  wire pop_ok = (|fifo_pop) && pop_ready;
  wire push   = pop_ok && !emp[psel];

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_fifo
      localparam [3:0] D = (g == 0) ? `ADSS_DEP0 : (g == 1) ? `ADSS_DEP1 :
                           (g == 2) ? `ADSS_DEP2 : `ADSS_DEP3;
      reg  [9:0] mem [0:7];
      reg  [2:0] wp_r;
      reg  [2:0] rp_r;
      reg  [3:0] cnt_r;
      reg        ovf_r;
      reg        unf_r;
      wire       full = (cnt_r == D);
      wire       wr   = fw_en && (fw_seq_r == g);
      wire       rd   = push && (psel == g);
      wire       bad  = pop_ok && (psel == g) && (cnt_r == 4'h0);

      always @(posedge clk) begin
        if (sys_rst) begin
          wp_r  <= 3'h0;
          rp_r  <= 3'h0;
          cnt_r <= 4'h0;
          ovf_r <= 1'b0;
          unf_r <= 1'b0;
        end else begin
          if (wr && !full) begin
            mem[wp_r] <= fw_data;
            wp_r <= ({1'b0, wp_r} == D - 4'h1) ? 3'h0 : wp_r + 3'h1;
          end
          if (rd)
            rp_r <= ({1'b0, rp_r} == D - 4'h1) ? 3'h0 : rp_r + 3'h1;
          cnt_r <= cnt_r + {3'h0, wr && !full} - {3'h0, rd};
          ovf_r <= (ovf_r && !ovf_clear[g]) || (wr && full);
          unf_r <= (unf_r && !unf_clear[g]) || bad;
        end
      end

      assign hd[10*g +: 10]        = mem[rp_r];
      assign emp[g]                = (cnt_r == 4'h0);
      assign head_ptrs[3*g +: 3]   = rp_r;
      assign tail_ptrs[3*g +: 3]   = wp_r;
      assign fifo_full[g]          = full;
      assign fifo_overflow_flags[g]  = ovf_r;
      assign fifo_underflow_flags[g] = unf_r;
    end
  endgenerate

  assign fifo_empty = emp;

  // ---------------------------------------------
  // Two-entry read buffer
  // ---------------------------------------------
  reg  [9:0] b0_r;
  reg  [9:0] b1_r;
  reg  [1:0] bc_r;
  wire       drain = rd_valid && rd_ready;
  wire [9:0] pw    = hd[10*psel +: 10];

  assign rd_valid  = (bc_r != 2'h0);
  assign pop_ready = (bc_r != 2'h2);
  assign result_fifo_port = {22'h000000, b0_r};

  always @(posedge clk) begin
    if (sys_rst) begin
      b0_r <= 10'h000;
      b1_r <= 10'h000;
      bc_r <= 2'h0;
    end else begin
      if (drain)
        b0_r <= b1_r;
      if (push) begin
        if (bc_r == 2'h0 || (bc_r == 2'h1 && drain))
          b0_r <= pw;
        else
          b1_r <= pw;
      end
      bc_r <= bc_r + {1'b0, push} - {1'b0, drain};
    end
  end

endmodule
`default_nettype wire

/* tb/adss_props.sv */
// Port-level checks for the sample sequencer
`timescale 1ns/10ps
`default_nettype none
module adss_props (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [3:0]  fifo_pop,
  input wire logic        pop_ready,
  input wire logic [3:0]  fifo_empty,
  input wire logic        rd_valid,
  input wire logic        rd_ready,
  input wire logic [31:0] result_fifo_port,
  input wire logic [3:0]  raw_irq_flags,
  input wire logic [3:0]  masked_irq_flags,
  input wire logic [3:0]  irq_gate_reg,
  input wire logic        adc_irq,
  input wire logic [3:0]  masked_irq_clear_reg,
  input wire logic        conv_valid,
  input wire logic        loopback_test_reg,
  input wire logic        pri_wr,
  input wire logic [7:0]  pri_wdata,
  input wire logic [7:0]  sequencer_priority_reg,
  input wire logic        conv_req,
  input wire logic [3:0]  conv_pos,
  input wire logic [3:0]  conv_neg,
  input wire logic        conv_diff,
  input wire logic [3:0]  fifo_underflow_flags
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_pop0;
    fifo_pop == 4'h1 && pop_ready;
  endsequence
  sequence s_rst_gone;
    $past(sys_rst);
  endsequence
  a_word_low: assert property (rd_valid |-> result_fifo_port[31:10] == 22'h0)
    else $error("result word upper bits set");
  a_pop_data: assert property (s_pop0 ##0 !fifo_empty[0] |=> rd_valid)
    else $error("pop gave no word");
  a_pop_under: assert property (s_pop0 ##0 fifo_empty[0] |=> fifo_underflow_flags[0])
    else $error("underflow not flagged");
  a_rd_hold: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(result_fifo_port))
    else $error("stalled word lost");
  a_mask_and: assert property (masked_irq_flags == (raw_irq_flags & irq_gate_reg))
    else $error("masked status wrong");
  a_irq_or: assert property (adc_irq == |masked_irq_flags)
    else $error("interrupt output wrong");
  a_clear_raw: assert property ((masked_irq_clear_reg != 4'h0) && !loopback_test_reg && !$past(conv_valid)
    |=> (raw_irq_flags & $past(masked_irq_clear_reg)) == 4'h0) else $error("clear ignored");
  a_pri_rst: assert property (s_rst_gone |-> sequencer_priority_reg == 8'hE4)
    else $error("priority reset value wrong");
  a_pri_load: assert property (pri_wr |=> sequencer_priority_reg == $past(pri_wdata))
    else $error("priority not loaded");
  a_diff_pair: assert property (conv_req && conv_diff |-> !conv_pos[0] && conv_neg == conv_pos + 4'h1)
    else $error("bad differential pair");
endmodule
bind adss_top adss_props u_props (.*);
`default_nettype wire

/* tb/adss_conv_model.sv */
// Behavioural converter answering each request after a set delay
`timescale 1ns/10ps
`default_nettype none
module adss_conv_model (
  input  wire logic       clk,
  input  wire logic       conv_req,
  input  wire logic [3:0] conv_pos,
  input  wire logic [3:0] conv_neg,
  input  wire logic       conv_diff,
  input  wire logic       conv_temp,
  input  wire logic [3:0] dly,
  output var  logic       conv_valid,
  output var  logic [9:0] conv_data
);
  logic [3:0] cnt_r = 4'h0;
  logic [9:0] word_r = 10'h0;
  // Code echoes the selects so every entry is predictable
  always @(posedge clk) begin
    conv_valid <= 1'b0;
    conv_data <= ~word_r;
    if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
    if (cnt_r == 4'h1) begin
      conv_valid <= 1'b1;
      conv_data <= word_r;
    end
    if (conv_req) begin
      cnt_r <= dly;
      word_r <= {conv_diff, conv_temp, conv_pos, conv_neg};
    end
  end
endmodule
`default_nettype wire

/* tb/adc_sample_sequencer_test.sv */
// Self-checking bench for the sample sequencer
`timescale 1ns/10ps
`default_nettype none
module adc_sample_sequencer_test;
  logic clk = 1'b0, sys_rst = 1'b1, pri_wr, loopback_test_reg, rd_ready;
  logic conv_req, conv_diff, conv_temp, conv_valid, pop_ready, rd_valid, adc_irq, seq_busy;
  logic [3:0] sequencer_enable_reg, ext_trig, software_trigger_bits, irq_gate_reg, dly;
  logic [3:0] masked_irq_clear_reg, raw_irq_flags, masked_irq_flags, conv_pos, conv_neg;
  logic [3:0] fifo_pop, fifo_full, fifo_empty, fifo_overflow_flags, ovf_clear;
  logic [3:0] fifo_underflow_flags, unf_clear;
  logic [67:0] step_input_select, step_control_nibbles;
  logic [15:0] trigger_source_select;
  logic [7:0] pri_wdata, sequencer_priority_reg;
  logic [2:0] averaging_control;
  logic [9:0] conv_data;
  logic [31:0] result_fifo_port;
  logic [11:0] head_ptrs, tail_ptrs;
  int fail_count = 0, checks_done = 0, cyc = 0, reqs = 0;
  adss_top dut (.*);
  adss_conv_model conv (.*);
  always #10 clk = ~clk;
  always @(negedge clk) reqs += conv_req;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      test_done;
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] g, e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task trig(logic [3:0] m);
    tick(1);
    software_trigger_bits = m;
    tick(1);
    software_trigger_bits = 4'h0;
  endtask
  task popraw(int s);
    tick(1);
    fifo_pop = 4'h1 << s;
    tick(1);
    fifo_pop = 4'h0;
  endtask
  task pop(int s, logic [31:0] e);
    popraw(s);
    chk(result_fifo_port, e);
  endtask
  // Idle only counts once busy stays low long enough to cover a pending start
  task wait_idle;
    int n, q;
    q = 0;
    for (n = 0; n < 600 && q < 8; n++) begin
      tick(1);
      q = (seq_busy === 1'b0) ? q + 1 : 0;
    end
    if (q < 8) chk(q, 8);
  endtask
  function logic [31:0] ew(logic d, logic [3:0] s);
    return d ? {24'h2, s[2:0], 1'b0, s[2:0], 1'b1} : {24'h0, s, 4'h0};
  endfunction
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_seq3;
    trig(4'h8);
    wait_idle;
    chk(fifo_empty[3], 1'b1);
    sequencer_enable_reg = 4'h8;
    trig(4'h8);
    wait_idle;
    chk({fifo_full[3], raw_irq_flags, adc_irq}, 6'h30);
    irq_gate_reg = 4'h8;
    tick(1);
    chk({masked_irq_flags, adc_irq}, 5'h11);
    masked_irq_clear_reg = 4'h7;
    tick(1);
    masked_irq_clear_reg = 4'h8;
    chk(raw_irq_flags, 4'h8);
    tick(1);
    masked_irq_clear_reg = 4'h0;
    chk({raw_irq_flags, adc_irq}, 5'h0);
    pop(3, ew(0, 4'h2));
  endtask
  task t_seq0;
    dly = 4'h6;
    sequencer_enable_reg = 4'h1;
    trig(4'h1);
    wait_idle;
    chk(tail_ptrs[2:0], 3'h5);
    rd_ready = 1'b0;
    pop(0, ew(0, 4'h0));
    pop(0, ew(0, 4'h0));
    chk(pop_ready, 1'b0);
    rd_ready = 1'b1;
    tick(1);
    chk(result_fifo_port, ew(1, 4'h1));
    pop(0, ew(0, 4'h2));
    pop(0, ew(1, 4'h3));
    pop(0, ew(0, 4'h4));
    popraw(0);
    chk({head_ptrs[2:0], fifo_empty[0], fifo_underflow_flags[0], rd_valid}, 6'h2E);
    unf_clear = 4'h1;
    tick(1);
    unf_clear = 4'h0;
    chk(fifo_underflow_flags, 4'h0);
  endtask
  task t_avg;
    averaging_control = 3'h2;
    sequencer_enable_reg = 4'h4;
    reqs = 0;
    trig(4'h4);
    wait_idle;
    chk(reqs, 4);
    pop(2, ew(0, 4'h3));
    // Codes above 6 clamp to a 64-sample group
    dly = 4'h1;
    averaging_control = 3'h7;
    reqs = 0;
    trig(4'h4);
    wait_idle;
    chk(reqs, 64);
    pop(2, ew(0, 4'h3));
    averaging_control = 3'h0;
  endtask
  task t_pri;
    int n;
    pri_wdata = 8'hC6;
    pri_wr = 1'b1;
    tick(1);
    pri_wr = 1'b0;
    chk(sequencer_priority_reg, 8'hC6);
    sequencer_enable_reg = 4'h6;
    trig(4'h6);
    for (n = 0; n < 50 && conv_req !== 1'b1; n++) tick(1);
    chk({conv_req, conv_pos}, 5'h13);
    wait_idle;
    pop(2, ew(0, 4'h3));
    pop(1, ew(0, 4'h1));
  endtask
  task t_loop_ovf;
    int n;
    loopback_test_reg = 1'b1;
    sequencer_enable_reg = 4'h8;
    reqs = 0;
    trig(4'h8);
    wait_idle;
    popraw(3);
    chk({reqs[3:0], result_fifo_port[9:5]}, 9'h018);
    loopback_test_reg = 1'b0;
    trigger_source_select = 16'hF000;
    for (n = 0; n < 400 && fifo_overflow_flags[3] !== 1'b1; n++) tick(1);
    chk({fifo_full[3], fifo_overflow_flags}, 5'h18);
    sequencer_enable_reg = 4'h0;
    wait_idle;
    ovf_clear = 4'h8;
    tick(1);
    ovf_clear = 4'h0;
    chk(fifo_overflow_flags, 4'h0);
  endtask
  task t_ext;
    step_control_nibbles[35:32] = 4'hA;
    trigger_source_select = 16'h0010;
    sequencer_enable_reg = 4'h2;
    tick(1);
    ext_trig = 4'h2;
    tick(1);
    ext_trig = 4'h0;
    wait_idle;
    chk(conv_temp, 1'b1);
    pop(1, 32'h00000110);
  endtask
  initial begin
    {pri_wr, loopback_test_reg, rd_ready, dly, pri_wdata, averaging_control} = 18'h08000;
    {sequencer_enable_reg, ext_trig, software_trigger_bits, irq_gate_reg} = 16'h0;
    {masked_irq_clear_reg, fifo_pop, ovf_clear, unf_clear, trigger_source_select} = 32'h0;
    rd_ready = 1'b1;
    dly = 4'h1;
    step_input_select = 68'h2_0003_0001_0004_3210;
    step_control_nibbles = 68'h6_0002_0002_0002_1010;
    tick(10);
    sys_rst = 1'b0;
    chk(sequencer_priority_reg, 8'hE4);
    chk({fifo_empty, fifo_full, raw_irq_flags}, 12'hF00);
    t_seq3;
    t_seq0;
    t_avg;
    t_pri;
    t_loop_ovf;
    t_ext;
    test_done;
  end
endmodule
`default_nettype wire
